// [logic/sild_pkg.sv]
package sild_pkg;

  // Timebase
  localparam int unsigned CLK_HZ         = 200000000;
  localparam int unsigned TICK_MS        = 50;
  localparam int unsigned TICK_CYCLES    = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned FLICKER_MS     = 50;
  localparam int unsigned BLINK_MS       = 200;
  localparam int unsigned FLASH_ON_MS    = 200;
  localparam int unsigned FLASH_GAP_MS   = 200;
  localparam int unsigned FLASH_OFF_MS   = 1000;
  localparam int unsigned FLICKER_TICKS  = FLICKER_MS / TICK_MS;
  localparam int unsigned BLINK_TICKS    = BLINK_MS / TICK_MS;
  localparam int unsigned ON_TICKS       = FLASH_ON_MS / TICK_MS;
  localparam int unsigned GAP_TICKS      = FLASH_GAP_MS / TICK_MS;
  localparam int unsigned OFF_TICKS      = FLASH_OFF_MS / TICK_MS;
  localparam int unsigned SINGLE_TICKS   = ON_TICKS + OFF_TICKS;
  localparam int unsigned DOUBLE_TICKS   = 2 * ON_TICKS + GAP_TICKS + OFF_TICKS;

  // AXI4-Lite register map
  localparam logic [7:0] ADDR_STATUS_IN  = 8'h00;
  localparam logic [7:0] ADDR_ERROR_IN   = 8'h04;
  localparam logic [7:0] ADDR_DISPLAY    = 8'h08;
  localparam logic [7:0] ADDR_PARAM      = 8'h0c;
  localparam logic [7:0] ADDR_LED_STATE  = 8'h10;
  localparam logic [1:0] RESP_OKAY       = 2'b00;
  localparam logic [1:0] RESP_SLVERR     = 2'b10;

  // STATUS_IN fields
  localparam int unsigned F_ESM          = 0;
  localparam int unsigned F_READY        = 4;
  localparam int unsigned F_SERVO_ON     = 5;
  localparam int unsigned F_IN_LINK      = 8;
  localparam int unsigned F_IN_ACT       = 9;
  localparam int unsigned F_OUT_LINK     = 10;
  localparam int unsigned F_OUT_ACT      = 11;
  localparam int unsigned F_POWER        = 12;
  // ERROR_IN fields
  localparam int unsigned F_ERR_REFUSED  = 0;
  localparam int unsigned F_ERR_AUTO     = 1;
  localparam int unsigned F_ERR_SM_WD    = 2;
  localparam int unsigned F_ERR_CRIT     = 3;
  // DISPLAY fields
  localparam int unsigned F_INIT_BUSY    = 0;
  localparam int unsigned F_TEST_MODE    = 1;
  localparam int unsigned F_CPU_ERR      = 2;
  localparam int unsigned F_SYS_DONE     = 3;
  localparam int unsigned F_ALARM        = 4;
  localparam int unsigned F_NET_CODE     = 8;
  localparam int unsigned F_ALARM_CODE   = 16;
  // PARAM fields
  localparam int unsigned F_PARAM_VAL    = 0;
  localparam int unsigned F_SW_RESET     = 31;

  // Reset values
  localparam logic [31:0] RST_REG        = 32'h0000_0000;
  localparam logic [23:0] RST_PARAM      = 24'h00_0000;

  // Fieldbus states
  localparam logic [3:0] ESM_INIT        = 4'h1;
  localparam logic [3:0] ESM_PREOP       = 4'h2;
  localparam logic [3:0] ESM_SAFEOP      = 4'h4;
  localparam logic [3:0] ESM_OP          = 4'h8;

  // 7-segment codes, segments g..a active high
  localparam logic [6:0] SEG_F           = 7'h71;
  localparam logic [6:0] SEG_TEST        = 7'h78;
  localparam logic [6:0] SEG_CPU_ERR     = 7'h79;
  localparam logic [6:0] SEG_BLANK       = 7'h00;

  typedef enum {PAT_OFF, PAT_ON, PAT_FLICKER, PAT_BLINK, PAT_SINGLE, PAT_DOUBLE} sild_pat_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] data;
  } sild_wr_t;

endpackage : sild_pkg

// [logic/sild_top.sv]
// Chosen here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - Flicker pattern toggles the LED every 50 ms (10 Hz).
// - Blink pattern toggles the LED every 200 ms (2.5 Hz).
// - Single flash: lit 200 ms, dark 1000 ms, repeating.
// - Double flash: lit 200, dark 200, lit 200, dark 1000 ms.
// - On holds the LED lit; off holds it dark.
// - Run LED dark in Init state or without power.
// - Run LED blinks in Pre-Operational.
// - Run LED single flash in Safe-Operational.
// - Run LED steady in Operational.
// - Error LED dark with no error; blinks on refused state change.
// - Error LED single flash on autonomous state change from internal error.
// - Error LED double flash on sync-manager watchdog error.
// - Error LED steady on critical error.
// - Separate link/activity LEDs for input and output ports.
// - Link LED dark without link or power.
// - Link LED steady with link and no traffic.
// - Link LED flickers with link and traffic.
// - Servo LED dark when not ready and servo off.
// - Servo LED blinks when ready and servo off.
// - Servo LED steady when ready and servo on.
// - Display shows F during init; codes for test mode and CPU error.
// - Restart parameters apply only after software reset; power cycle restores RST_PARAM.
// - After system check show network status, then alarm when active.
module sild_top (
  input  wire logic        CLK_SYS,
  input  wire logic        SYS_RST,
  input  wire logic [7:0]  AWADDR,
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output logic             WREADY,
  output logic [1:0]       BRESP,
  output logic             BVALID,
  input  wire logic        BREADY,
  input  wire logic [7:0]  ARADDR,
  input  wire logic        ARVALID,
  output logic             ARREADY,
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  output logic             RVALID,
  input  wire logic        RREADY,
  output logic             RUN_LED,
  output logic             ERROR_LED,
  output logic             SERVO_STATE_LED,
  output logic             IN_PORT_LINK_LED,
  output logic             OUT_PORT_LINK_LED,
  output logic [6:0]       SEGMENT,
  output logic [23:0]      PARAM_ACTIVE
);

  logic [31:0]        status_in;
  logic [31:0]        error_in;
  logic [31:0]        display;
  logic [23:0]        param_pend;
  logic               aw_held;
  logic               w_held;
  sild_pkg::sild_wr_t wr;
  logic               sw_reset;
  logic [23:0]        tick_cnt;
  logic               tick;

  // Lit/dark for a pattern at a given phase count
  function automatic logic pat_level(sild_pkg::sild_pat_t p, logic [5:0] ph);
    case (p)
      sild_pkg::PAT_ON:      pat_level = 1'b1;
      sild_pkg::PAT_FLICKER: pat_level = (ph % 6'(2 * sild_pkg::FLICKER_TICKS)) < 6'(sild_pkg::FLICKER_TICKS);
      sild_pkg::PAT_BLINK:   pat_level = (ph % 6'(2 * sild_pkg::BLINK_TICKS)) < 6'(sild_pkg::BLINK_TICKS);
      sild_pkg::PAT_SINGLE:  pat_level = ph < 6'(sild_pkg::ON_TICKS);
      sild_pkg::PAT_DOUBLE:  pat_level = (ph < 6'(sild_pkg::ON_TICKS)) ||
                                         (ph >= 6'(sild_pkg::ON_TICKS + sild_pkg::GAP_TICKS) &&
                                          ph < 6'(2 * sild_pkg::ON_TICKS + sild_pkg::GAP_TICKS));
      default:               pat_level = 1'b0;
    endcase
  endfunction

  // Length of one cycle of a pattern in ticks; six bits, double flash needs 32
  function automatic logic [5:0] pat_len(sild_pkg::sild_pat_t p);
    case (p)
      sild_pkg::PAT_FLICKER: pat_len = 6'(2 * sild_pkg::FLICKER_TICKS);
      sild_pkg::PAT_BLINK:   pat_len = 6'(2 * sild_pkg::BLINK_TICKS);
      sild_pkg::PAT_SINGLE:  pat_len = 6'(sild_pkg::SINGLE_TICKS);
      sild_pkg::PAT_DOUBLE:  pat_len = 6'(sild_pkg::DOUBLE_TICKS);
      default:               pat_len = 6'h01;
    endcase
  endfunction

  // Link LED pattern for one port
  function automatic sild_pkg::sild_pat_t link_pat(logic pwr, logic link, logic act);
    if (!pwr || !link) begin
      link_pat = sild_pkg::PAT_OFF;
    end else if (act) begin
      link_pat = sild_pkg::PAT_FLICKER;
    end else begin
      link_pat = sild_pkg::PAT_ON;
    end
  endfunction

  // AXI write: address and data captured in either order
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      AWREADY <= 1'b0;
      WREADY  <= 1'b0;
      BVALID  <= 1'b0;
      BRESP   <= sild_pkg::RESP_OKAY;
      wr      <= '0;
    end else begin
      AWREADY <= !aw_held && !AWREADY && AWVALID && !BVALID;
      WREADY  <= !w_held && !WREADY && WVALID && !BVALID;
      if (AWVALID && AWREADY) begin
        aw_held <= 1'b1;
        wr.addr <= AWADDR;
      end
      if (WVALID && WREADY) begin
        w_held  <= 1'b1;
        wr.data <= WDATA;
      end
      if (aw_held && w_held && !BVALID) begin
        BVALID  <= 1'b1;
        aw_held <= 1'b0;
        w_held  <= 1'b0;
        BRESP   <= (wr.addr == sild_pkg::ADDR_LED_STATE || wr.addr > sild_pkg::ADDR_LED_STATE ||
                    wr.addr[1:0] != 2'b00) ? sild_pkg::RESP_SLVERR : sild_pkg::RESP_OKAY;
      end else if (BVALID && BREADY) begin
        BVALID <= 1'b0;
      end
    end
  end

  // Register stores, done with the response; WSTRB ignored, whole words
  assign sw_reset = aw_held && w_held && !BVALID && wr.addr == sild_pkg::ADDR_PARAM &&
                    wr.data[sild_pkg::F_SW_RESET];
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      status_in  <= sild_pkg::RST_REG;
      error_in   <= sild_pkg::RST_REG;
      display    <= sild_pkg::RST_REG;
      param_pend <= sild_pkg::RST_PARAM;
    end else if (aw_held && w_held && !BVALID) begin
      case (wr.addr)
        sild_pkg::ADDR_STATUS_IN: status_in  <= wr.data;
        sild_pkg::ADDR_ERROR_IN:  error_in   <= wr.data;
        sild_pkg::ADDR_DISPLAY:   display    <= wr.data;
        sild_pkg::ADDR_PARAM:     param_pend <= wr.data[23:0];  // Held, not yet live
        default: ;
      endcase
    end
  end

  // Restart parameter takes effect only on software reset; reset loads RST_PARAM
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      PARAM_ACTIVE <= sild_pkg::RST_PARAM;
    end else if (sw_reset) begin
      PARAM_ACTIVE <= wr.data[23:0];
    end
  end

  // AXI read, one word per request
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      ARREADY <= 1'b0;
      RVALID  <= 1'b0;
      RDATA   <= 32'h0000_0000;
      RRESP   <= sild_pkg::RESP_OKAY;
    end else begin
      ARREADY <= !ARREADY && !RVALID && ARVALID;
      if (ARVALID && ARREADY) begin
        RVALID <= 1'b1;
        RRESP  <= sild_pkg::RESP_OKAY;
        case (ARADDR)
          sild_pkg::ADDR_STATUS_IN: RDATA <= status_in;
          sild_pkg::ADDR_ERROR_IN:  RDATA <= error_in;
          sild_pkg::ADDR_DISPLAY:   RDATA <= display;
          sild_pkg::ADDR_PARAM:     RDATA <= {8'h00, param_pend};
          sild_pkg::ADDR_LED_STATE: RDATA <= {16'h0000, PARAM_ACTIVE == param_pend, SEGMENT,
                                              3'h0, OUT_PORT_LINK_LED, IN_PORT_LINK_LED,
                                              SERVO_STATE_LED, ERROR_LED, RUN_LED};
          default: begin
            RDATA <= 32'h0000_0000;
            RRESP <= sild_pkg::RESP_SLVERR;
          end
        endcase
      end else if (RVALID && RREADY) begin
        RVALID <= 1'b0;
      end
    end
  end

  // Shared 50 ms timebase, cleared by reset
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST || tick) begin
      tick_cnt <= 24'h00_0000;
    end else begin
      tick_cnt <= tick_cnt + 24'h00_0001;
    end
  end
  assign tick = tick_cnt == 24'(sild_pkg::TICK_CYCLES - 1);

  // Alarm/network time slice, one tick each; coarse so the digit stays readable
  logic seg_slice;
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      seg_slice <= 1'b0;
    end else if (tick) begin
      seg_slice <= !seg_slice;
    end
  end

  // Pattern selection per LED
  sild_pkg::sild_pat_t pat [5];
  logic pwr;
  assign pwr = status_in[sild_pkg::F_POWER];

  always_comb begin
    // Run LED from fieldbus state
    case (status_in[sild_pkg::F_ESM +: 4])
      sild_pkg::ESM_PREOP:  pat[0] = sild_pkg::PAT_BLINK;
      sild_pkg::ESM_SAFEOP: pat[0] = sild_pkg::PAT_SINGLE;
      sild_pkg::ESM_OP:     pat[0] = sild_pkg::PAT_ON;
      default:              pat[0] = sild_pkg::PAT_OFF;
    endcase
    if (!pwr) begin
      pat[0] = sild_pkg::PAT_OFF;
    end
    // Error LED, worst condition first
    if (error_in[sild_pkg::F_ERR_CRIT]) begin
      pat[1] = sild_pkg::PAT_ON;
    end else if (error_in[sild_pkg::F_ERR_SM_WD]) begin
      pat[1] = sild_pkg::PAT_DOUBLE;
    end else if (error_in[sild_pkg::F_ERR_AUTO]) begin
      pat[1] = sild_pkg::PAT_SINGLE;
    end else if (error_in[sild_pkg::F_ERR_REFUSED]) begin
      pat[1] = sild_pkg::PAT_BLINK;
    end else begin
      pat[1] = sild_pkg::PAT_OFF;
    end
    // Servo state LED
    if (!status_in[sild_pkg::F_READY]) begin
      pat[2] = sild_pkg::PAT_OFF;
    end else if (!status_in[sild_pkg::F_SERVO_ON]) begin
      pat[2] = sild_pkg::PAT_BLINK;
    end else begin
      pat[2] = sild_pkg::PAT_ON;
    end
    // Independent link LEDs for both ports
    pat[3] = link_pat(pwr, status_in[sild_pkg::F_IN_LINK], status_in[sild_pkg::F_IN_ACT]);
    pat[4] = link_pat(pwr, status_in[sild_pkg::F_OUT_LINK], status_in[sild_pkg::F_OUT_ACT]);
  end

  // Phase counters; each restarts on its own pattern change
  sild_pkg::sild_pat_t pat_q [5];
  logic [5:0]          phase [5];
  logic [4:0]          led_q;
  always_ff @(posedge CLK_SYS) begin
    for (int i = 0; i < 5; i++) begin
      if (SYS_RST) begin
        pat_q[i] <= sild_pkg::PAT_OFF;
        phase[i] <= 6'h00;
        led_q[i] <= 1'b0;
      end else begin
        pat_q[i] <= pat[i];
        if (pat[i] != pat_q[i]) begin
          phase[i] <= 6'h00;  // Back to first lit phase
          led_q[i] <= pat_level(pat[i], 6'h00);
        end else begin
          if (tick) begin
            phase[i] <= (phase[i] + 6'h01 >= pat_len(pat[i])) ? 6'h00 : phase[i] + 6'h01;
          end
          led_q[i] <= pat_level(pat[i], phase[i]);
        end
      end
    end
  end
  assign RUN_LED           = led_q[0];
  assign ERROR_LED         = led_q[1];
  assign SERVO_STATE_LED   = led_q[2];
  assign IN_PORT_LINK_LED  = led_q[3];
  assign OUT_PORT_LINK_LED = led_q[4];

  // Seven-segment: special codes, then network status, then alarm
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      SEGMENT <= sild_pkg::SEG_F;
    end else if (display[sild_pkg::F_CPU_ERR]) begin
      SEGMENT <= sild_pkg::SEG_CPU_ERR;
    end else if (display[sild_pkg::F_INIT_BUSY] || !display[sild_pkg::F_SYS_DONE]) begin
      SEGMENT <= sild_pkg::SEG_F;
    end else if (display[sild_pkg::F_TEST_MODE]) begin
      SEGMENT <= sild_pkg::SEG_TEST;
    end else if (display[sild_pkg::F_ALARM] && seg_slice) begin
      SEGMENT <= display[sild_pkg::F_ALARM_CODE +: 7];  // Alarm follows network status
    end else begin
      SEGMENT <= display[sild_pkg::F_NET_CODE +: 7];
    end
  end

endmodule // sild_top
`default_nettype wire

// [verification/sild_monitor.sv]
`timescale 1ns/100ps
`default_nettype none
// Bus handshakes, display and restart parameter seen at the top ports only
module sild_monitor (
  input wire logic        CLK_SYS, SYS_RST, AWVALID, AWREADY, WVALID, WREADY,
  input wire logic        BVALID, BREADY, ARVALID, ARREADY, RVALID, RREADY,
  input wire logic        RUN_LED, ERROR_LED,
  input wire logic [1:0]  BRESP, RRESP,
  input wire logic [31:0] RDATA,
  input wire logic [6:0]  SEGMENT,
  input wire logic [23:0] PARAM_ACTIVE
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);

  // Leaving reset shows the busy glyph with the run and error lamps dark
  property p_out_of_reset;
    $fell(SYS_RST) |-> SEGMENT == sild_pkg::SEG_F && !RUN_LED && !ERROR_LED;
  endproperty
  a_out_of_reset: assert property (p_out_of_reset) else $error("wrong outputs after reset");
  // Live parameter moves only on a completed write, never by itself
  property p_param_hold;
    $changed(PARAM_ACTIVE) |-> $rose(BVALID);
  endproperty
  a_param_hold: assert property (p_param_hold) else $error("parameter changed outside a write");
  // Ready strobes are single pulses
  property p_aw_pulse;
    AWREADY |=> !AWREADY;
  endproperty
  a_aw_pulse: assert property (p_aw_pulse) else $error("address ready held");
  property p_ar_pulse;
    ARREADY |=> !ARREADY;
  endproperty
  a_ar_pulse: assert property (p_ar_pulse) else $error("read address ready held");
  // Answers come in time and stand with their payload until taken
  property p_b_hold;
    BVALID && !BREADY |=> BVALID && $stable(BRESP);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_r_hold;
    RVALID && !RREADY |=> RVALID && $stable(RDATA) && $stable(RRESP);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read response dropped");
  property p_r_next;
    ARVALID && ARREADY |=> RVALID;
  endproperty
  a_r_next: assert property (p_r_next) else $error("read data late");
  property p_b_after;
    AWVALID && AWREADY && WVALID && WREADY |-> ##[1:3] BVALID;
  endproperty
  a_b_after: assert property (p_b_after) else $error("write response missing");
  // Refused reads carry no stale data
  property p_err_zero;
    RVALID && RRESP == sild_pkg::RESP_SLVERR |-> RDATA == 32'h0;
  endproperty
  a_err_zero: assert property (p_err_zero) else $error("refused read returned data");

  c_write: cover property (BVALID && BREADY);
  c_read: cover property (RVALID && RREADY);
  c_err_lit: cover property ($rose(ERROR_LED));
  c_param: cover property ($changed(PARAM_ACTIVE));
endmodule // sild_monitor
`default_nettype wire

// [verification/sild_panel.sv]
`timescale 1ns/100ps
`default_nettype none
// Front panel: lamps and the single digit latch what the block drives
module sild_panel (
  input  wire logic       clk,
  input  wire logic [4:0] led_drive,
  input  wire logic [6:0] seg_drive,
  output var logic [4:0]  lamp,
  output var logic [6:0]  glyph
);
  // One clock late, like a registered panel driver; bench waits it out
  always_ff @(posedge clk) begin
    lamp  <= led_drive;
    glyph <= seg_drive;
  end
endmodule // sild_panel
`default_nettype wire

// [verification/tb_status_indicator_led_driver.sv]
`timescale 1ns/100ps
`default_nettype none
module tb_status_indicator_led_driver;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rd, s, e, v;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, resp;
  wire logic [4:0] leds;
  logic [4:0]  lamp, exp_l;
  logic [6:0]  segment, glyph;
  logic [23:0] param_active;
  int          num_errors = 0;
  int          tests_run = 0;
  localparam logic [3:0] ESM_TAB [5] = '{sild_pkg::ESM_INIT, sild_pkg::ESM_PREOP, sild_pkg::ESM_SAFEOP,
                                        sild_pkg::ESM_OP, 4'h0};

  always #2.5 clk = ~clk;

  sild_top dut_u (.CLK_SYS(clk), .SYS_RST(rst), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
    .WDATA(wdata), .WSTRB(4'hf), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid),
    .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp),
    .RVALID(rvalid), .RREADY(rready), .RUN_LED(leds[4]), .ERROR_LED(leds[3]), .SERVO_STATE_LED(leds[2]),
    .IN_PORT_LINK_LED(leds[1]), .OUT_PORT_LINK_LED(leds[0]), .SEGMENT(segment), .PARAM_ACTIVE(param_active));
  sild_panel panel_u (.clk(clk), .led_drive(leds), .seg_drive(segment), .lamp(lamp), .glyph(glyph));

  // Every pattern except off opens lit, so a fresh condition shows as lit or dark
  function automatic logic [4:0] exp_leds(input logic [31:0] st, input logic [31:0] er);
    logic       pw;
    logic [3:0] m;
    pw = st[sild_pkg::F_POWER];
    m = st[3:0];
    return {pw && (m == sild_pkg::ESM_PREOP || m == sild_pkg::ESM_SAFEOP || m == sild_pkg::ESM_OP),
            |er[3:0], st[sild_pkg::F_READY], pw && st[sild_pkg::F_IN_LINK], pw && st[sild_pkg::F_OUT_LINK]};
  endfunction

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge clk);
  endtask

  // Block answers within two clocks, the panel adds one
  task automatic settle;
    repeat (5) @(posedge clk);
  endtask

  task automatic disp(input logic [31:0] d, input logic [6:0] g);
    wr(sild_pkg::ADDR_DISPLAY, d, resp);
    settle;
    chk("segment", {25'h0, g}, {25'h0, glyph});
  endtask

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Watchdog: whole run needs under a thousand cycles
  initial begin
    #500_000;
    num_errors++;
    final_report;
  end

  initial begin
    s = $urandom(32'hd157);
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("glyph", {25'h0, sild_pkg::SEG_F}, {25'h0, glyph});
    chk("lamps", 32'h0, {27'h0, lamp});
    rd_reg(sild_pkg::ADDR_STATUS_IN, rd, resp);
    chk("status reset", sild_pkg::RST_REG, rd);
    $display("test reset done");
    // First five pass every state powered; sixth is unpowered with links up
    for (int i = 0; i < 24; i++) begin
      s = $urandom & 32'h1f3f;
      e = $urandom & 32'hf;
      s[3:0] = ESM_TAB[i % 5];
      if (!s[4]) s[5] = 1'b0;
      if (i < 5) s[12] = 1'b1;
      if (i == 5) s = 32'h538;
      wr(sild_pkg::ADDR_STATUS_IN, s, resp);
      wr(sild_pkg::ADDR_ERROR_IN, e, resp);
      settle;
      chk("leds", {27'h0, exp_leds(s, e)}, {27'h0, lamp});
      rd_reg(sild_pkg::ADDR_STATUS_IN, rd, resp);
      chk("status", s, rd);
    end
    $display("test leds done");
    v = $urandom;
    disp(32'h1, sild_pkg::SEG_F);
    disp(32'hb, sild_pkg::SEG_F);
    disp(32'he, sild_pkg::SEG_CPU_ERR);
    disp(32'ha, sild_pkg::SEG_TEST);
    disp({17'h0, v[6:0], 8'h08}, v[6:0]);
    disp({9'h0, v[14:8], 1'b0, v[6:0], 8'h18}, v[6:0]);
    disp(32'h0, sild_pkg::SEG_F);
    $display("test display done");
    v = $urandom & 32'h00ff_ffff;
    wr(sild_pkg::ADDR_PARAM, v, resp);
    settle;
    chk("param held", {8'h0, sild_pkg::RST_PARAM}, {8'h0, param_active});
    rd_reg(sild_pkg::ADDR_PARAM, rd, resp);
    chk("param pending", v, rd);
    wr(sild_pkg::ADDR_PARAM, v | 32'h8000_0000, resp);
    settle;
    chk("param live", v, {8'h0, param_active});
    chk("param resp", {30'h0, sild_pkg::RESP_OKAY}, {30'h0, resp});
    exp_l = exp_leds(s, e);
    rd_reg(sild_pkg::ADDR_LED_STATE, rd, resp);
    chk("led state", {16'h0, 1'b1, sild_pkg::SEG_F, 3'h0, exp_l[0], exp_l[1], exp_l[2], exp_l[3], exp_l[4]}, rd);
    $display("test param done");
    wr(sild_pkg::ADDR_LED_STATE, 32'hffff_ffff, resp);
    chk("ro write", {30'h0, sild_pkg::RESP_SLVERR}, {30'h0, resp});
    wr(8'h14, 32'h1, resp);
    chk("unmapped write", {30'h0, sild_pkg::RESP_SLVERR}, {30'h0, resp});
    rd_reg(8'h20, rd, resp);
    chk("unmapped read", {30'h0, sild_pkg::RESP_SLVERR}, {30'h0, resp});
    chk("unmapped data", 32'h0, rd);
    $display("test refused done");
    final_report;
  end
endmodule // tb_status_indicator_led_driver

bind sild_top sild_monitor u_mon (.CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .AWVALID(AWVALID), .AWREADY(AWREADY),
  .WVALID(WVALID), .WREADY(WREADY), .BVALID(BVALID), .BREADY(BREADY), .ARVALID(ARVALID), .ARREADY(ARREADY),
  .RVALID(RVALID), .RREADY(RREADY), .RUN_LED(RUN_LED), .ERROR_LED(ERROR_LED), .BRESP(BRESP), .RRESP(RRESP),
  .RDATA(RDATA), .SEGMENT(SEGMENT), .PARAM_ACTIVE(PARAM_ACTIVE));
`default_nettype wire
